//--- pcaw_regs.sv
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
module pcaw_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic lsi_tick,
    input wire logic supply_below_raw,
    output logic [2:0] detector_threshold_select,
    output logic supply_monitor_enable,
    output logic deep_sleep_standby_select,
    output logic supply_event_out,
    output logic wake_event_out,
    output logic irq
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic [2:0] thresh_reg;
    logic [2:0] thresh_next;
    logic mon_en_reg;
    logic mon_en_next;
    logic standby_reg;
    logic standby_next;
    logic awu_en_reg;
    logic awu_en_next;
    logic [5:0] window_reg;
    logic [5:0] window_next;
    logic [3:0] psc_reg;
    logic [3:0] psc_next;
    logic [1:0] evt_status_reg;
    logic [1:0] evt_status_next;
    logic [1:0] evt_mask_reg;
    logic [1:0] evt_mask_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic below_reg;
    logic det_prev_reg;
    logic det_now;
    logic crossing;
    logic [1:0] evt_set;
    logic [1:0] evt_clr;
    logic [31:0] rd_value;
    logic count_tick;
    logic [6:0] count_value;
    logic wake_pulse;

    pcaw_prescaler u_prescaler (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(awu_en_reg),
        .lsi_tick(lsi_tick),
        .prescale_select(psc_reg),
        .count_tick(count_tick)
    );

    pcaw_wake_counter u_counter (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(awu_en_reg),
        .count_tick(count_tick),
        .window_value(window_reg),
        .count_value(count_value),
        .wake_pulse(wake_pulse)
    );

    // Detector output and crossing detection
    always_comb
    begin
        det_now = mon_en_reg & below_reg;
        crossing = det_now ^ det_prev_reg;
        evt_set = 2'h0;
        evt_set[pcaw_pkg::EVT_SUPPLY_BIT] = crossing;
        evt_set[pcaw_pkg::EVT_WAKE_BIT] = wake_pulse;
    end

    // Register writes
    always_comb
    begin
        thresh_next = thresh_reg;
        mon_en_next = mon_en_reg;
        standby_next = standby_reg;
        awu_en_next = awu_en_reg;
        window_next = window_reg;
        psc_next = psc_reg;
        evt_mask_next = evt_mask_reg;
        evt_clr = 2'h0;
        if (bus_wr)
        begin
            case (bus_addr)
                pcaw_pkg::OFF_POWER_CONTROL:
                begin
                    thresh_next = bus_wdata[pcaw_pkg::THRESH_MSB:pcaw_pkg::THRESH_LSB];
                    mon_en_next = bus_wdata[pcaw_pkg::MON_EN_BIT];
                    standby_next = bus_wdata[pcaw_pkg::STANDBY_BIT];
                end
                pcaw_pkg::OFF_WAKEUP_CONTROL:
                begin
                    awu_en_next = bus_wdata[pcaw_pkg::AWU_EN_BIT];
                end
                pcaw_pkg::OFF_WAKEUP_WINDOW:
                begin
                    window_next = bus_wdata[pcaw_pkg::WINDOW_MSB:0];
                end
                pcaw_pkg::OFF_WAKEUP_PRESCALE:
                begin
                    psc_next = bus_wdata[pcaw_pkg::PSC_MSB:0];
                end
                pcaw_pkg::OFF_EVENT_STATUS:
                begin
                    evt_clr = bus_wdata[pcaw_pkg::EVT_W-1:0];
                end
                pcaw_pkg::OFF_EVENT_MASK:
                begin
                    evt_mask_next = bus_wdata[pcaw_pkg::EVT_W-1:0];
                end
                default:
                begin
                    evt_clr = 2'h0;
                end
            endcase
        end
        // Set wins over a simultaneous clear
        evt_status_next = (evt_status_reg & ~evt_clr) | evt_set;
    end

    // Read mux, reserved bits zero
    always_comb
    begin
        rd_value = 32'h0000_0000;
        case (bus_addr)
            pcaw_pkg::OFF_POWER_CONTROL:
            begin
                rd_value[pcaw_pkg::THRESH_MSB:pcaw_pkg::THRESH_LSB] = thresh_reg;
                rd_value[pcaw_pkg::MON_EN_BIT] = mon_en_reg;
                rd_value[pcaw_pkg::STANDBY_BIT] = standby_reg;
            end
            pcaw_pkg::OFF_POWER_STATUS:
            begin
                rd_value[pcaw_pkg::BELOW_FLAG_BIT] = below_reg;
            end
            pcaw_pkg::OFF_WAKEUP_CONTROL:
            begin
                rd_value[pcaw_pkg::AWU_EN_BIT] = awu_en_reg;
            end
            pcaw_pkg::OFF_WAKEUP_WINDOW:
            begin
                rd_value[pcaw_pkg::WINDOW_MSB:0] = window_reg;
            end
            pcaw_pkg::OFF_WAKEUP_PRESCALE:
            begin
                rd_value[pcaw_pkg::PSC_MSB:0] = psc_reg;
            end
            pcaw_pkg::OFF_EVENT_STATUS:
            begin
                rd_value[pcaw_pkg::EVT_W-1:0] = evt_status_reg;
            end
            pcaw_pkg::OFF_EVENT_MASK:
            begin
                rd_value[pcaw_pkg::EVT_W-1:0] = evt_mask_reg;
            end
            default:
            begin
                rd_value = 32'h0000_0000;
            end
        endcase
        rdata_next = bus_rd ? rd_value : 32'h0000_0000;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            thresh_reg <= pcaw_pkg::THRESH_RST;
            mon_en_reg <= 1'b0;
            standby_reg <= 1'b0;
            awu_en_reg <= 1'b0;
            window_reg <= pcaw_pkg::WINDOW_RST;
            psc_reg <= pcaw_pkg::PSC_RST;
            evt_status_reg <= pcaw_pkg::EVT_RST;
            evt_mask_reg <= pcaw_pkg::EVT_RST;
            rdata_reg <= 32'h0000_0000;
            det_prev_reg <= 1'b0;
        end
        else
        begin
            thresh_reg <= thresh_next;
            mon_en_reg <= mon_en_next;
            standby_reg <= standby_next;
            awu_en_reg <= awu_en_next;
            window_reg <= window_next;
            psc_reg <= psc_next;
            evt_status_reg <= evt_status_next;
            evt_mask_reg <= evt_mask_next;
            rdata_reg <= rdata_next;
            det_prev_reg <= det_now;
        end
    end

    // Comparator sample, no reset value
    always_ff @(posedge clk)
    begin
        below_reg <= supply_below_raw;
    end

    assign bus_rdata = rdata_reg;
    assign detector_threshold_select = thresh_reg;
    assign supply_monitor_enable = mon_en_reg;
    assign deep_sleep_standby_select = standby_reg;
    assign supply_event_out = det_prev_reg;
    assign wake_event_out = wake_pulse;
    assign irq = |(evt_status_reg & evt_mask_reg);

    sequence ctrl_write_s;
        bus_wr && bus_addr == pcaw_pkg::OFF_POWER_CONTROL;
    endsequence

    sequence ctrl_read_s;
        bus_rd && bus_addr == pcaw_pkg::OFF_POWER_CONTROL;
    endsequence

    sequence status_read_s;
        bus_rd && bus_addr == pcaw_pkg::OFF_POWER_STATUS;
    endsequence

    sequence match_s;
        awu_en_reg && count_tick && (count_value + 7'h01) == pcaw_pkg::pcaw_eff_window(window_reg);
    endsequence

    thresh_write_a: assert property (ctrl_write_s |=>
        detector_threshold_select == $past(bus_wdata[7:5]))
        else $error("Threshold select not updated by write");

    mon_en_write_a: assert property (ctrl_write_s |=>
        supply_monitor_enable == $past(bus_wdata[4]))
        else $error("Detector enable not updated by write");

    standby_sel_a: assert property (ctrl_write_s ##1 ctrl_read_s |=>
        bus_rdata[1] == deep_sleep_standby_select && deep_sleep_standby_select == $past(bus_wdata[1], 2))
        else $error("Standby select readback mismatch");

    below_flag_a: assert property (status_read_s |=>
        bus_rdata[2] == $past(below_reg) && bus_rdata[1:0] == 2'h0)
        else $error("Below-threshold flag read wrong");

    awu_off_quiet_a: assert property (!awu_en_reg [*2] |-> !wake_event_out)
        else $error("Wake-up raised while auto-wakeup disabled");

    window_write_a: assert property (
        bus_wr && bus_addr == pcaw_pkg::OFF_WAKEUP_WINDOW |=> window_reg == $past(bus_wdata[5:0]))
        else $error("Window value not updated by write");

    wake_on_match_a: assert property (match_s |=> wake_event_out ##1 !wake_event_out)
        else $error("Wake-up not a one-cycle pulse at window match");

    no_early_wake_a: assert property (
        awu_en_reg && count_tick && (count_value + 7'h01) < pcaw_pkg::pcaw_eff_window(window_reg)
        |=> !wake_event_out)
        else $error("Wake-up before effective window reached");

    reserved_zero_a: assert property (ctrl_read_s |=>
        bus_rdata[31:8] == 24'h000000 && bus_rdata[3:2] == 2'h0 && bus_rdata[0] == 1'b0)
        else $error("Reserved control bits not zero");

    supply_event_a: assert property ($changed(supply_event_out) |-> evt_status_reg[0])
        else $error("Detector crossing did not set status");

    wake_status_a: assert property (wake_event_out |=> evt_status_reg[1])
        else $error("Wake-up did not set status");

endmodule : pcaw_regs

//--- pcaw_pkg.sv
package pcaw_pkg;

    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_POWER_CONTROL = 8'h00;
    localparam logic [7:0] OFF_POWER_STATUS = 8'h04;
    localparam logic [7:0] OFF_WAKEUP_CONTROL = 8'h08;
    localparam logic [7:0] OFF_WAKEUP_WINDOW = 8'h0c;
    localparam logic [7:0] OFF_WAKEUP_PRESCALE = 8'h10;
    localparam logic [7:0] OFF_EVENT_STATUS = 8'h14;
    localparam logic [7:0] OFF_EVENT_MASK = 8'h18;

    // Field positions
    localparam int THRESH_MSB = 7;
    localparam int THRESH_LSB = 5;
    localparam int MON_EN_BIT = 4;
    localparam int STANDBY_BIT = 1;
    localparam int BELOW_FLAG_BIT = 2;
    localparam int AWU_EN_BIT = 1;
    localparam int WINDOW_MSB = 5;
    localparam int PSC_MSB = 3;
    localparam int EVT_SUPPLY_BIT = 0;
    localparam int EVT_WAKE_BIT = 1;

    // Widths
    localparam int THRESH_W = 3;
    localparam int WINDOW_W = 6;
    localparam int CNT_W = 7;
    localparam int PSC_W = 4;
    localparam int DIV_W = 16;
    localparam int EVT_W = 2;

    // Reset values
    localparam logic [2:0] THRESH_RST = 3'h0;
    localparam logic [5:0] WINDOW_RST = 6'h3f;
    localparam logic [3:0] PSC_RST = 4'h0;
    localparam logic [1:0] EVT_RST = 2'h0;

    // Low-speed time base and event line routing
    localparam int LSI_FREQ_KHZ = 128;
    localparam int SUPPLY_EVENT_LINE = 8;
    localparam int WAKE_EVENT_LINE = 9;

    // Division ratio for each prescale code
    function automatic logic [15:0] pcaw_div_ratio(input logic [3:0] sel);
        logic [15:0] r;
        r = 16'h0001;
        case (sel)
            4'h0: r = 16'h0001;
            4'h1: r = 16'h0001;
            4'h2: r = 16'h0002;
            4'h3: r = 16'h0004;
            4'h4: r = 16'h0008;
            4'h5: r = 16'h0010;
            4'h6: r = 16'h0020;
            4'h7: r = 16'h0040;
            4'h8: r = 16'h0080;
            4'h9: r = 16'h0100;
            4'ha: r = 16'h0200;
            4'hb: r = 16'h0400;
            4'hc: r = 16'h0800;
            4'hd: r = 16'h1000;
            4'he: r = 16'h2800;
            4'hf: r = 16'hf000;
            default: r = 16'h0001;
        endcase
        return r;
    endfunction : pcaw_div_ratio

    // Effective window is the programmed field plus one
    function automatic logic [6:0] pcaw_eff_window(input logic [5:0] w);
        return {1'b0, w} + 7'h01;
    endfunction : pcaw_eff_window

endpackage : pcaw_pkg

//--- pcaw_prescaler.sv
`timescale 1ns/100ps
module pcaw_prescaler (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic lsi_tick,
    input wire logic [3:0] prescale_select,
    output logic count_tick
);

    logic [15:0] div_cnt_reg;
    logic [15:0] div_cnt_next;
    logic count_tick_reg;
    logic count_tick_next;
    logic [15:0] ratio;

    // Divide low-speed ticks by the selected ratio
    always_comb
    begin
        ratio = pcaw_pkg::pcaw_div_ratio(prescale_select);
        div_cnt_next = div_cnt_reg;
        count_tick_next = 1'b0;
        if (!run)
        begin
            div_cnt_next = 16'h0000;
        end
        else if (lsi_tick)
        begin
            if (div_cnt_reg >= ratio - 16'h0001)
            begin
                div_cnt_next = 16'h0000;
                count_tick_next = 1'b1;
            end
            else
            begin
                div_cnt_next = div_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_cnt_reg <= 16'h0000;
            count_tick_reg <= 1'b0;
        end
        else
        begin
            div_cnt_reg <= div_cnt_next;
            count_tick_reg <= count_tick_next;
        end
    end

    assign count_tick = count_tick_reg;

    psc_bypass_a: assert property (@(posedge clk) disable iff (sys_rst)
        (run && lsi_tick && prescale_select <= 4'h1) |=> count_tick)
        else $error("Prescaler off did not pass every tick");

endmodule : pcaw_prescaler

//--- pcaw_wake_counter.sv
`timescale 1ns/100ps
module pcaw_wake_counter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic count_tick,
    input wire logic [5:0] window_value,
    output logic [6:0] count_value,
    output logic wake_pulse
);

    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    logic wake_reg;
    logic wake_next;
    logic [6:0] eff;
    logic [6:0] inc;

    // Up counter compared against the effective window
    always_comb
    begin
        eff = pcaw_pkg::pcaw_eff_window(window_value);
        inc = cnt_reg + 7'h01;
        cnt_next = cnt_reg;
        wake_next = 1'b0;
        if (!run)
        begin
            cnt_next = 7'h00;
        end
        else if (count_tick)
        begin
            if (inc >= eff)
            begin
                cnt_next = 7'h00;
                wake_next = 1'b1;
            end
            else
            begin
                cnt_next = inc;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 7'h00;
            wake_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            wake_reg <= wake_next;
        end
    end

    assign count_value = cnt_reg;
    assign wake_pulse = wake_reg;

    count_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
        wake_pulse |-> (count_value == 7'h00))
        else $error("Counter did not restart after wake-up");

endmodule : pcaw_wake_counter

//--- pcaw_regs_test.sv
`timescale 1ns/100ps
module pcaw_regs_test;
    logic clk;
    logic sys_rst;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] bus_rdata;
    logic lsi_tick;
    logic supply_below_raw;
    logic [2:0] detector_threshold_select;
    logic supply_monitor_enable;
    logic deep_sleep_standby_select;
    logic supply_event_out;
    logic wake_event_out;
    logic irq;
    logic lsi_run;
    logic [1:0] lsi_cnt;
    int n_mismatch;
    int checked;

    pcaw_regs dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .lsi_tick(lsi_tick),
        .supply_below_raw(supply_below_raw),
        .detector_threshold_select(detector_threshold_select),
        .supply_monitor_enable(supply_monitor_enable),
        .deep_sleep_standby_select(deep_sleep_standby_select),
        .supply_event_out(supply_event_out),
        .wake_event_out(wake_event_out),
        .irq(irq)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Low-speed tick, one pulse every four cycles
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            lsi_cnt <= 2'h0;
            lsi_tick <= 1'b0;
        end
        else
        begin
            lsi_cnt <= lsi_cnt + 2'h1;
            lsi_tick <= lsi_run && (lsi_cnt == 2'h3);
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : check

    task automatic bus_write(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= addr;
        bus_wdata <= data;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : bus_write

    task automatic read_check(input logic [7:0] addr, input logic [31:0] exp);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= addr;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        check(bus_rdata, exp);
    endtask : read_check

    // Write, then read back in the very next cycle
    task automatic write_read(input logic [7:0] addr, input logic [31:0] data, input logic [31:0] exp);
        bus_write(addr, data);
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        check(bus_rdata, exp);
    endtask : write_read

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : results

    // Waits for a wake pulse, counting low-speed ticks on the way
    task automatic wait_wake(output int ticks);
        int i;
        ticks = 0;
        for (i = 0; i < 4000; i++)
        begin
            @(posedge clk);
            #1;
            if (lsi_tick === 1'b1)
                ticks++;
            if (wake_event_out === 1'b1)
                break;
        end
        if (i == 4000)
        begin
            $display("Error at %0t: wake timeout got %h expected %h", $time, wake_event_out, 1'b1);
            n_mismatch++;
            results();
        end
    endtask : wait_wake

    logic [5:0] win_tab [5] = '{6'h00, 6'h02, 6'h01, 6'h03, 6'h00};
    logic [3:0] psc_tab [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7};
    int ratio_tab [5] = '{1, 1, 2, 4, 64};

    initial
    begin
        int t;
        sys_rst = 1'b1;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        lsi_run = 1'b0;
        supply_below_raw = 1'b0;
        n_mismatch = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset values and unmapped place
        read_check(pcaw_pkg::OFF_POWER_CONTROL, 32'h0);
        read_check(pcaw_pkg::OFF_WAKEUP_CONTROL, 32'h0);
        read_check(pcaw_pkg::OFF_WAKEUP_WINDOW, 32'h0000003f);
        read_check(pcaw_pkg::OFF_WAKEUP_PRESCALE, 32'h0);
        read_check(pcaw_pkg::OFF_EVENT_STATUS, 32'h0);
        read_check(pcaw_pkg::OFF_EVENT_MASK, 32'h0);
        read_check(8'h1c, 32'h0);
        check({31'h0, irq}, 32'h0);
        // Reserved bits masked on the control, wake-up control and window registers
        write_read(pcaw_pkg::OFF_POWER_CONTROL, 32'hffffffff, 32'h000000f2);
        check({29'h0, detector_threshold_select}, 32'h7);
        check({31'h0, supply_monitor_enable}, 32'h1);
        check({31'h0, deep_sleep_standby_select}, 32'h1);
        bus_write(pcaw_pkg::OFF_WAKEUP_CONTROL, 32'hfffffffd);
        read_check(pcaw_pkg::OFF_WAKEUP_CONTROL, 32'h0);
        bus_write(pcaw_pkg::OFF_WAKEUP_WINDOW, 32'hffffffc5);
        read_check(pcaw_pkg::OFF_WAKEUP_WINDOW, 32'h00000005);
        bus_write(8'h1c, 32'hffffffff);
        read_check(8'h1c, 32'h0);
        // Every threshold code, standby select cleared
        for (int c = 0; c < 8; c++)
        begin
            write_read(pcaw_pkg::OFF_POWER_CONTROL, 32'(c) << 5, 32'(c) << 5);
            check({29'h0, detector_threshold_select}, 32'(c));
            check({30'h0, supply_monitor_enable, deep_sleep_standby_select}, 32'h0);
        end
        // Supply detector: crossing both ways, flag, event, interrupt
        bus_write(pcaw_pkg::OFF_EVENT_STATUS, 32'h3);
        supply_below_raw <= 1'b1;
        bus_write(pcaw_pkg::OFF_POWER_CONTROL, 32'h00000010);
        idle(4);
        check({31'h0, supply_event_out}, 32'h1);
        read_check(pcaw_pkg::OFF_POWER_STATUS, 32'h00000004);
        read_check(pcaw_pkg::OFF_EVENT_STATUS, 32'h1);
        check({31'h0, irq}, 32'h0);
        bus_write(pcaw_pkg::OFF_EVENT_MASK, 32'hffffffff);
        read_check(pcaw_pkg::OFF_EVENT_MASK, 32'h3);
        check({31'h0, irq}, 32'h1);
        bus_write(pcaw_pkg::OFF_EVENT_STATUS, 32'h1);
        supply_below_raw <= 1'b0;
        idle(1);
        check({31'h0, irq}, 32'h0);
        idle(4);
        check({31'h0, supply_event_out}, 32'h0);
        read_check(pcaw_pkg::OFF_POWER_STATUS, 32'h0);
        read_check(pcaw_pkg::OFF_EVENT_STATUS, 32'h1);
        bus_write(pcaw_pkg::OFF_EVENT_STATUS, 32'h1);
        bus_write(pcaw_pkg::OFF_EVENT_MASK, 32'h2);
        // Auto-wakeup periods: (window + 1) * ratio ticks
        lsi_run <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            bus_write(pcaw_pkg::OFF_WAKEUP_CONTROL, 32'h0);
            bus_write(pcaw_pkg::OFF_WAKEUP_WINDOW, {26'h0, win_tab[k]});
            bus_write(pcaw_pkg::OFF_WAKEUP_PRESCALE, {28'h0, psc_tab[k]});
            read_check(pcaw_pkg::OFF_WAKEUP_PRESCALE, {28'h0, psc_tab[k]});
            bus_write(pcaw_pkg::OFF_WAKEUP_CONTROL, 32'h2);
            read_check(pcaw_pkg::OFF_WAKEUP_CONTROL, 32'h2);
            wait_wake(t);
            wait_wake(t);
            check(32'(t), 32'((win_tab[k] + 1) * ratio_tab[k]));
            wait_wake(t);
            check(32'(t), 32'((win_tab[k] + 1) * ratio_tab[k]));
        end
        idle(2);
        read_check(pcaw_pkg::OFF_EVENT_STATUS, 32'h2);
        check({31'h0, irq}, 32'h1);
        // Disabled unit raises no wake
        bus_write(pcaw_pkg::OFF_WAKEUP_CONTROL, 32'h0);
        bus_write(pcaw_pkg::OFF_EVENT_STATUS, 32'h2);
        idle(100);
        read_check(pcaw_pkg::OFF_EVENT_STATUS, 32'h0);
        check({31'h0, irq}, 32'h0);
        results();
    end
endmodule : pcaw_regs_test
